// ### dv/rpim_host_model.sv
// Host model that acknowledges the request line by clearing all status.
`timescale 1ns/1ps
`default_nettype none
module rpim_host_model (
  // Clock, request line and service control.
  input wire logic mclk,
  input wire logic irq,
  input wire logic serve,
  input wire logic [1:0] lag,
  // Clearing writes; the bench supplies all-ones data while hWrite is high.
  output logic hWrite,
  output logic [7:0] hAddr
);
  // After a chosen delay, write ones to the three status registers.
  initial begin
    hWrite = 1'h0;
    hAddr = 8'h20;
    forever begin
      @(negedge mclk);
      if (serve && irq) begin
        repeat (lag) @(negedge mclk);
        for (int a = 32; a < 35; a++) begin
          hWrite = 1'h1;
          hAddr = a[7:0];
          @(negedge mclk);
        end
        hWrite = 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/rpim_irq_mask_monitor.sv
// Port-level checker of the interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
module rpim_irq_mask_monitor (
  // Clock, reset and register port.
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  // Events and request line.
  input wire logic [10:0] refFault,
  input wire logic [2:0] loopUnlock,
  input wire logic [2:0] loopHoldover,
  input wire logic irq
);
  logic [16:0] enSh_ff;
  logic [16:0] ev;
  logic [7:0] enView;
  logic clrWr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Shadow of the enables, so gating can be judged from the ports alone.
  always @(posedge mclk) begin
    if (!reset_n) enSh_ff <= 17'h00000;
    else if (regWrite && regAddr == 8'h23) enSh_ff[7:0] <= regWrData;
    else if (regWrite && regAddr == 8'h24) enSh_ff[10:8] <= regWrData[2:0];
    else if (regWrite && regAddr == 8'h25) enSh_ff[16:11] <= regWrData[5:0];
  end
  // Enabled events and the expected enable read view.
  assign ev = {loopUnlock[2], loopHoldover[2], loopUnlock[1], loopHoldover[1], loopUnlock[0], loopHoldover[0],
    refFault} & enSh_ff;
  assign clrWr = regWrite && regAddr inside {[8'h20:8'h22]};
  assign enView = regAddr == 8'h23 ? enSh_ff[7:0] : regAddr == 8'h24 ? {5'h00, enSh_ff[10:8]} : {2'h0, enSh_ff[16:11]};
  AST_REF_IRQ: assert property (|ev[10:0] |-> ##2 irq) else $error("Reference fault raised no request.");
  AST_LOOP_IRQ: assert property (|ev[16:11] |-> ##2 irq) else $error("Loop event raised no request.");
  AST_MASKED_QUIET: assert property (!(|ev) ##1 !irq |=> !irq) else $error("Request without enabled event.");
  AST_STICKY: assert property (!clrWr ##1 irq |=> irq) else $error("Request dropped without a clear.");
  AST_RD_VALID: assert property (regRead |=> regRdValid) else $error("Read gave no valid pulse.");
  AST_NO_STRAY: assert property (!regRead |=> !regRdValid) else $error("Valid pulse without a read.");
  AST_EN_READ: assert property (regRead && regAddr inside {[8'h23:8'h25]} |=> regRdData == $past(enView))
    else $error("Enable read back wrong.");
  AST_UNMAPPED: assert property (regRead && !(regAddr inside {[8'h20:8'h25]}) |=> regRdData == 8'h00)
    else $error("Unmapped read not zero.");
  AST_RD_HOLD: assert property (!regRead |=> $stable(regRdData)) else $error("Read data moved without a read.");
  cover property (|ev[10:0] ##2 irq);
  cover property (|ev[16:11] ##2 irq);
  cover property (clrWr && irq);
  cover property (clrWr && |ev);
endmodule
bind rpim_irq_mask rpim_irq_mask_monitor u_rpim_irq_mask_monitor (.mclk, .reset_n, .regAddr, .regWrite, .regWrData,
  .regRead, .regRdData, .regRdValid, .refFault, .loopUnlock, .loopHoldover, .irq);
`default_nettype wire

// ### dv/rpim_irq_mask_tb.sv
// Self-checking bench of the interrupt enable block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module rpim_irq_mask_tb;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic wrT = 1'h0;
  logic rdT = 1'h0;
  logic serve = 1'h0;
  logic [7:0] adrT = 8'h00;
  logic [7:0] datT = 8'h00;
  logic [1:0] lag = 2'h0;
  logic [16:0] ev = 17'h00000;
  logic [16:0] b;
  logic [31:0] r;
  logic [7:0] regAddr, regWrData, regRdData, hAddr, expHead;
  logic regWrite, regRdValid, irq, hWrite;
  logic [7:0] expQ[$];
  int mismatches = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  // The host model takes the port only while it clears status.
  assign regWrite = wrT | hWrite;
  assign regAddr = hWrite ? hAddr : adrT;
  assign regWrData = hWrite ? 8'hFF : datT;
  rpim_irq_mask u_rpim_irq_mask (.mclk, .reset_n, .regAddr, .regWrite, .regWrData, .regRead(rdT), .regRdData,
    .regRdValid, .refFault(ev[10:0]), .loopUnlock({ev[16], ev[14], ev[12]}), .loopHoldover({ev[15], ev[13], ev[11]}), .irq);
  rpim_host_model u_rpim_host_model (.mclk, .irq, .serve, .lag, .hWrite, .hAddr);
  // Read data is compared in order against the notes queued by the driver.
  always @(negedge mclk) begin
    if (regRdValid === 1'h1) begin
      expHead = expQ.pop_front();
      `CHK("regRdData", expHead, regRdData)
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    adrT = a;
    datT = d;
    wrT = 1'h1;
    @(negedge mclk);
    wrT = 1'h0;
  endtask
  // Write with an event level standing at that same edge, for the clear-against-set race.
  task automatic wrEv(input logic [7:0] a, input logic [7:0] d, input logic [16:0] v);
    @(negedge mclk);
    ev = v;
    adrT = a;
    datT = d;
    wrT = 1'h1;
    @(negedge mclk);
    ev = 17'h00000;
    wrT = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    adrT = a;
    rdT = 1'h1;
    expQ.push_back(e);
    @(negedge mclk);
    rdT = 1'h0;
  endtask
  task automatic setEn(input logic [16:0] v);
    wr(8'h23, v[7:0]);
    wr(8'h24, {5'h00, v[10:8]});
    wr(8'h25, {2'h0, v[16:11]});
  endtask
  task automatic chkSt(input logic [16:0] v);
    rd(8'h20, v[7:0]);
    rd(8'h21, {5'h00, v[10:8]});
    rd(8'h22, {2'h0, v[16:11]});
  endtask
  // One-cycle event, then time for flag and request to settle.
  task automatic pulse(input logic [16:0] v);
    @(negedge mclk);
    ev = v;
    @(negedge mclk);
    ev = 17'h00000;
    repeat (2) @(negedge mclk);
  endtask
  task automatic tally_and_finish;
    repeat (3) @(negedge mclk);
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence: reset values, enable access, then every event masked and enabled.
  initial begin
    void'($urandom(48));
    repeat (12) @(negedge mclk);
    reset_n = 1'h1;
    for (int a = 32; a < 40; a++) rd(a[7:0], 8'h00);
    $display("reset values done");
    r = $urandom;
    wr(8'h23, r[7:0]);
    wr(8'h24, r[15:8]);
    wr(8'h25, r[23:16]);
    wr(8'h26, 8'hFF);
    rd(8'h23, r[7:0]);
    rd(8'h24, {5'h00, r[10:8]});
    rd(8'h25, {2'h0, r[21:16]});
    rd(8'h26, 8'h00);
    $display("enable access done");
    for (int i = 0; i < 17; i++) begin
      b = 17'h00001 << i;
      setEn(~b);
      pulse(b);
      chkSt(17'h00000);
      `CHK("irq", 1'h0, irq)
      setEn(b);
      pulse(b);
      chkSt(b);
      `CHK("irq", 1'h1, irq)
      lag <= 2'($urandom);
      serve <= 1'h1;
      for (int k = 0; k < 20 && irq === 1'h1; k++) @(negedge mclk);
      serve <= 1'h0;
      `CHK("irq", 1'h0, irq)
      chkSt(17'h00000);
    end
    $display("event gating done");
    // Reserved enable bits, then clears that meet a new event on the same edge: the set must win.
    wr(8'h24, 8'hFF);
    wr(8'h25, 8'hFF);
    wr(8'h23, 8'hFF);
    rd(8'h24, 8'h07);
    rd(8'h25, 8'h3F);
    wrEv(8'h20, 8'h01, 17'h00001);
    wrEv(8'h22, 8'h01, 17'h00800);
    chkSt(17'h00801);
    `CHK("irq", 1'h1, irq)
    // Closing the enables must not hide flags that are already set.
    setEn(17'h00000);
    chkSt(17'h00801);
    `CHK("irq", 1'h1, irq)
    wr(8'h20, 8'h01);
    wr(8'h22, 8'h01);
    chkSt(17'h00000);
    `CHK("irq", 1'h0, irq)
    $display("set and clear race done");
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of some eight hundred cycles.
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### verilog/rpim_defines.vh
// Register map, field layout and reset values of the reference and loop interrupt enable block.
`ifndef RPIM_DEFINES_VH
`define RPIM_DEFINES_VH

// Register port geometry.
`define RPIM_ADDR_W 8
`define RPIM_DATA_W 8

// Register offsets.
`define RPIM_ADDR_REF_STATUS_LOW 8'h20
`define RPIM_ADDR_REF_STATUS_HIGH 8'h21
`define RPIM_ADDR_LOOP_STATUS 8'h22
`define RPIM_ADDR_REF_ENABLE_LOW 8'h23
`define RPIM_ADDR_REF_ENABLE_HIGH 8'h24
`define RPIM_ADDR_LOOP_ENABLE 8'h25

// Event counts and used field widths.
`define RPIM_NUM_REFS 11
`define RPIM_REF_LOW_W 8
`define RPIM_REF_HIGH_W 3
`define RPIM_NUM_LOOPS 3
`define RPIM_LOOP_W 6

// Field positions inside the loop registers: loop k holdover at 2k, unlock at 2k+1.
`define RPIM_LOOP_HOLD_OFS 0
`define RPIM_LOOP_UNLOCK_OFS 1
`define RPIM_LOOP_STRIDE 2

// Reset values.
`define RPIM_RST_REF_LOW 8'h00
`define RPIM_RST_REF_HIGH 3'h0
`define RPIM_RST_LOOP 6'h00
`define RPIM_RST_REF_ALL 11'h000
`define RPIM_RST_DATA 8'h00

`endif

// ### verilog/rpim_irq_mask.v
// Interrupt enable masking and sticky status for reference faults and loop lock/holdover events.
// Register map as software sees it:
//   0x20  reference fault flags 7..0, write one to clear.
//   0x21  reference fault flags 10..8 in bits 2..0, write one to clear.
//   0x22  loop event flags, write one to clear.
//   0x23  reference fault enables 7..0.
//   0x24  reference fault enables 10..8 in bits 2..0.
//   0x25  loop event enables.
// In both loop registers loop k holdover sits at bit 2k and its loss-of-lock at bit 2k+1.
//
// A flag sets on the edge that sees its enabled event; irq follows one edge later.
// Events are levels and a set wins over a clear on the same edge, so a condition still present keeps its flag set through a clear;
// software should clear a flag only once its source has gone quiet.
// Read data appears one cycle after the strobe, with regRdValid high for that one cycle,
// and then holds until the next read.
// After reset every enable and flag is zero, so nothing interrupts until software opens an enable.
`include "rpim_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module rpim_irq_mask (
  // Clock and reset.
  input wire mclk,
  input wire reset_n,
  // Register port from the serial configuration interface.
  input wire [`RPIM_ADDR_W-1:0] regAddr,
  input wire regWrite,
  input wire [`RPIM_DATA_W-1:0] regWrData,
  input wire regRead,
  output reg [`RPIM_DATA_W-1:0] regRdData,
  output reg regRdValid,
  // Event levels from the reference monitors and the loops.
  input wire [`RPIM_NUM_REFS-1:0] refFault,
  input wire [`RPIM_NUM_LOOPS-1:0] loopUnlock,
  input wire [`RPIM_NUM_LOOPS-1:0] loopHoldover,
  // Interrupt request to the host, active high.
  output reg irq
);

  // Enable registers; only the defined bits are stored, so reserved bits cannot be set.
  // Writing the reserved upper bits therefore has no effect, and they always read back as zero.
  reg [`RPIM_REF_LOW_W-1:0] refEnableLow_ff;
  reg [`RPIM_REF_HIGH_W-1:0] refEnableHigh_ff;
  reg [`RPIM_LOOP_W-1:0] loopEnable_ff;
  reg [`RPIM_REF_LOW_W-1:0] nxt_refEnableLow;
  reg [`RPIM_REF_HIGH_W-1:0] nxt_refEnableHigh;
  reg [`RPIM_LOOP_W-1:0] nxt_loopEnable;

  // Read path and interrupt flops.
  reg [`RPIM_DATA_W-1:0] rdData_ff;
  reg [`RPIM_DATA_W-1:0] nxt_rdData;
  reg rdValid_ff;
  reg irq_ff;

  // Status flags and the per-flag clear strobes.
  wire [`RPIM_NUM_REFS-1:0] refStatus;
  wire [`RPIM_LOOP_W-1:0] loopStatus;
  wire [`RPIM_NUM_REFS-1:0] refClear;
  wire [`RPIM_LOOP_W-1:0] loopClear;
  wire [`RPIM_NUM_REFS-1:0] refEnableAll;
  wire [`RPIM_LOOP_W-1:0] loopEvents;
  wire anyFlag;

  // Address decode for writes.
  wire wrRefStatusLow;
  wire wrRefStatusHigh;
  wire wrLoopStatus;
  wire wrRefEnableLow;
  wire wrRefEnableHigh;
  wire wrLoopEnable;

  // One write strobe per register; an unmapped offset matches none, so its write is dropped.
  assign wrRefStatusLow = regWrite & (regAddr == `RPIM_ADDR_REF_STATUS_LOW);
  assign wrRefStatusHigh = regWrite & (regAddr == `RPIM_ADDR_REF_STATUS_HIGH);
  assign wrLoopStatus = regWrite & (regAddr == `RPIM_ADDR_LOOP_STATUS);
  assign wrRefEnableLow = regWrite & (regAddr == `RPIM_ADDR_REF_ENABLE_LOW);
  assign wrRefEnableHigh = regWrite & (regAddr == `RPIM_ADDR_REF_ENABLE_HIGH);
  assign wrLoopEnable = regWrite & (regAddr == `RPIM_ADDR_LOOP_ENABLE);

  // Next values of the enable registers; upper written bits are dropped on purpose.
  always @* begin
    nxt_refEnableLow = refEnableLow_ff;
    nxt_refEnableHigh = refEnableHigh_ff;
    nxt_loopEnable = loopEnable_ff;
    if (wrRefEnableLow) begin
      nxt_refEnableLow = regWrData[`RPIM_REF_LOW_W-1:0];
    end
    if (wrRefEnableHigh) begin
      nxt_refEnableHigh = regWrData[`RPIM_REF_HIGH_W-1:0];
    end
    if (wrLoopEnable) begin
      nxt_loopEnable = regWrData[`RPIM_LOOP_W-1:0];
    end
  end

  // Enable registers reset to all zero, so every event starts masked.
  always @(posedge mclk) begin
    if (!reset_n) begin
      refEnableLow_ff <= `RPIM_RST_REF_LOW;
      refEnableHigh_ff <= `RPIM_RST_REF_HIGH;
      loopEnable_ff <= `RPIM_RST_LOOP;
    end else begin
      refEnableLow_ff <= nxt_refEnableLow;
      refEnableHigh_ff <= nxt_refEnableHigh;
      loopEnable_ff <= nxt_loopEnable;
    end
  end

  // Reference n uses enable bit n; 8..10 come from the high register.
  assign refEnableAll = {refEnableHigh_ff, refEnableLow_ff};

  // Interleave loop events so each status bit sits at the position of its enable bit.
  // Keeping one bit layout for enables and flags lets software use one mask for both.
  genvar k;
  generate
    for (k = 0; k < `RPIM_NUM_LOOPS; k = k + 1) begin : g_loop
      assign loopEvents[`RPIM_LOOP_STRIDE*k+`RPIM_LOOP_HOLD_OFS] = loopHoldover[k];
      assign loopEvents[`RPIM_LOOP_STRIDE*k+`RPIM_LOOP_UNLOCK_OFS] = loopUnlock[k];
    end
  endgenerate

  // Write-one-to-clear strobes for the sticky flags.
  assign refClear = {regWrData[`RPIM_REF_HIGH_W-1:0] & {`RPIM_REF_HIGH_W{wrRefStatusHigh}},
                     regWrData[`RPIM_REF_LOW_W-1:0] & {`RPIM_REF_LOW_W{wrRefStatusLow}}};
  assign loopClear = regWrData[`RPIM_LOOP_W-1:0] & {`RPIM_LOOP_W{wrLoopStatus}};

  // Sticky reference fault flags.
  rpim_sticky_bank #(
    .W(`RPIM_NUM_REFS)
  ) u_refBank (
    .mclk(mclk),
    .reset_n(reset_n),
    .eventIn(refFault),
    .enable(refEnableAll),
    .clearReq(refClear),
    .flags(refStatus)
  );

  // Sticky loop unlock and holdover flags.
  rpim_sticky_bank #(
    .W(`RPIM_LOOP_W)
  ) u_loopBank (
    .mclk(mclk),
    .reset_n(reset_n),
    .eventIn(loopEvents),
    .enable(loopEnable_ff),
    .clearReq(loopClear),
    .flags(loopStatus)
  );

  // Read multiplexer; unmapped offsets and reserved bits read as zero.
  // A read and a write to one offset in the same cycle return the old value, as the mux sees the flops.
  always @* begin
    nxt_rdData = `RPIM_RST_DATA;
    case (regAddr)
      `RPIM_ADDR_REF_STATUS_LOW: begin
        nxt_rdData = refStatus[`RPIM_REF_LOW_W-1:0];
      end
      `RPIM_ADDR_REF_STATUS_HIGH: begin
        nxt_rdData[`RPIM_REF_HIGH_W-1:0] = refStatus[`RPIM_NUM_REFS-1:`RPIM_REF_LOW_W];
      end
      `RPIM_ADDR_LOOP_STATUS: begin
        nxt_rdData[`RPIM_LOOP_W-1:0] = loopStatus;
      end
      `RPIM_ADDR_REF_ENABLE_LOW: begin
        nxt_rdData = refEnableLow_ff;
      end
      `RPIM_ADDR_REF_ENABLE_HIGH: begin
        nxt_rdData[`RPIM_REF_HIGH_W-1:0] = refEnableHigh_ff;
      end
      `RPIM_ADDR_LOOP_ENABLE: begin
        nxt_rdData[`RPIM_LOOP_W-1:0] = loopEnable_ff;
      end
      default: begin
        nxt_rdData = `RPIM_RST_DATA;
      end
    endcase
  end

  // Any latched flag asks for service. Enables are not applied a second time here, so turning an
  // enable off does not hide a flag that is already set; software has to clear it.
  assign anyFlag = (|refStatus) | (|loopStatus);

  // Read data is registered so the port sees a clean value one cycle after the strobe.
  // The interrupt follows the flags one cycle late; that keeps the pin glitch free.
  // The request is a level: it stays high while any flag is set.
  always @(posedge mclk) begin
    if (!reset_n) begin
      rdData_ff <= `RPIM_RST_DATA;
      rdValid_ff <= 1'h0;
      irq_ff <= 1'h0;
    end else begin
      rdValid_ff <= regRead;
      if (regRead) begin
        rdData_ff <= nxt_rdData;
      end
      irq_ff <= anyFlag;
    end
  end

  // Outputs come straight from flops.
  always @* begin
    regRdData = rdData_ff;
    regRdValid = rdValid_ff;
    irq = irq_ff;
  end

endmodule

`default_nettype wire

// ### verilog/rpim_sticky_bank.v
// Bank of sticky interrupt status bits, each gated by its own enable.
`timescale 1ns/1ps
`default_nettype none

module rpim_sticky_bank #(
  parameter W = 8
) (
  // Clock and reset.
  input wire mclk,
  input wire reset_n,
  // Raw event levels and their enables.
  input wire [W-1:0] eventIn,
  input wire [W-1:0] enable,
  // Software clear, one bit per flag, write-one-to-clear.
  input wire [W-1:0] clearReq,
  // Latched flags.
  output wire [W-1:0] flags
);

  reg [W-1:0] flag_ff;
  wire [W-1:0] nxt_flag;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // A gated event sets the flag; it wins over a clear in the same cycle so no event is lost.
      assign nxt_flag[i] = (eventIn[i] & enable[i]) ? 1'h1 :
                           (clearReq[i] ? 1'h0 : flag_ff[i]);
    end
  endgenerate

  // Flags hold until cleared, even after the condition goes away.
  always @(posedge mclk) begin
    if (!reset_n) begin
      flag_ff <= {W{1'h0}};
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flags = flag_ff;

endmodule

`default_nettype wire
